// ---- twi_slave.sv ----
`timescale 1ns/1ns
// Contract
// - Master clocks; device never drives SCL
// - Lines only pulled low or released
// - Reset slave address is 0x38
// - Select bit clear: straps choose bank only
// - Select bit set: straps pick address
// - Bank A gains reset to 0x30
// - Bank B gains reset to 0x3F
// - Gain bits 7:6 stored, no effect
// - Start detected, bus busy
// - Stop detected, bus free
// - Eight bits MSB first, then acknowledge
// - SDA changes only while SCL low
// - Ninth clock: receiver pulls SDA low
// - Not-acknowledge leaves SDA high
// - First byte: address plus direction
// - Acknowledge only matching slave address
// - First write byte sets pointer
// - Later write bytes stored, pointer advances
// - Direction bit steers following data bytes
// - Reads start at pointer, default zero
// - Master NOT_ACKNOWLEDGE ends device data drive
// - Address matched even without start
// - Writing select bit latches strap pins
module twi_slave
  import twi_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire logic SCL_I,
  output logic SCL_O,
  output logic SCL_OE_O,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_O,
  input wire logic BANK_STRAP_PIN_ZERO_I,
  input wire logic BANK_STRAP_PIN_ONE_I,
  output logic [5:0] CH0_GAIN_O,
  output logic [5:0] CH1_GAIN_O
);

  // ----------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------
  logic [3:0] pin_raw;
  logic [3:0] pin_f;
  logic scl_f;
  logic sda_f;
  logic [1:0] strap;

  assign pin_raw = {BANK_STRAP_PIN_ONE_I, BANK_STRAP_PIN_ZERO_I,
                    SDA_I, SCL_I};

  for (genvar i = 0; i < 4; i++) begin : g_pin
    pin_filter #(
      .LEN(FILTER_LEN)
    ) u_filter (
      .clk_i(CLK_I),
      .rst_n_i(RSTN_I),
      .pin_i(pin_raw[i]),
      .level_o(pin_f[i])
    );
  end

  assign scl_f = pin_f[0];
  assign sda_f = pin_f[1];
  assign strap = pin_f[3:2];

  // ----------------------------------------------------------------
  // Bus events
  // ----------------------------------------------------------------
  logic scl_p_q;
  logic sda_p_q;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;

  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_f;
      sda_p_q <= sda_f;
    end
  end

  assign scl_rise = scl_f && !scl_p_q;
  assign scl_fall = !scl_f && scl_p_q;
  assign start_ev = scl_f && scl_p_q && sda_p_q && !sda_f;
  assign stop_ev = scl_f && scl_p_q && !sda_p_q && sda_f;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic wr_en_q;
  logic [7:0] wr_addr_q;
  logic [7:0] wr_data_q;
  logic [7:0] ptr_q;
  logic [7:0] rd_data;
  logic addr_mode;
  logic [1:0] addr_sel;
  logic [3:0][5:0] gain;
  logic [6:0] slave_addr;

  config_regs u_regs (
    .clk_i(CLK_I),
    .rst_n_i(RSTN_I),
    .wr_en_i(wr_en_q),
    .wr_addr_i(wr_addr_q),
    .wr_data_i(wr_data_q),
    .rd_addr_i(ptr_q),
    .rd_data_o(rd_data),
    .strap_i(strap),
    .addr_mode_o(addr_mode),
    .addr_sel_o(addr_sel),
    .gain_o(gain)
  );

  // Address follows latched straps only in select mode
  assign slave_addr = addr_mode
                    ? (SLAVE_ADDR_BASE | {4'h0, addr_sel, 1'b0})
                    : SLAVE_ADDR_BASE;

  // ----------------------------------------------------------------
  // Gain outputs, bank chosen by straps
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      CH0_GAIN_O <= GAIN_A_RESET[5:0];
      CH1_GAIN_O <= GAIN_A_RESET[5:0];
    end else begin
      CH0_GAIN_O <= strap[0] ? gain[1] : gain[0];
      CH1_GAIN_O <= strap[1] ? gain[3] : gain[2];
    end
  end

  // ----------------------------------------------------------------
  // Fixed pin drives
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      SCL_O <= 1'b0;
      SCL_OE_O <= 1'b0;
      SDA_O <= 1'b0;
    end else begin
      SCL_O <= 1'b0;
      SCL_OE_O <= 1'b0;
      SDA_O <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Serial engine
  // ----------------------------------------------------------------
  state_t state_q;
  logic [3:0] cnt_q;
  logic [7:0] rx_q;
  logic [7:0] tx_q;
  logic rw_q;
  logic ptr_next_q;
  logic mack_q;
  logic addr_match;

  assign addr_match = (rx_q[7:1] == slave_addr) && (cnt_q == 4'h8);

  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      rx_q <= 8'h00;
      tx_q <= 8'h00;
      rw_q <= 1'b0;
      ptr_next_q <= 1'b0;
      mack_q <= 1'b0;
      ptr_q <= PTR_RESET;
      SDA_OE_O <= 1'b0;
      wr_en_q <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
    end else begin
      wr_en_q <= 1'b0;
      if (start_ev) begin
        state_q <= ST_ADDR;
        cnt_q <= 4'h0;
        SDA_OE_O <= 1'b0;
      end else if (stop_ev) begin
        state_q <= ST_IDLE;
        cnt_q <= 4'h0;
        SDA_OE_O <= 1'b0;
      end else begin
        case (state_q)
          ST_IDLE, ST_ADDR: begin
            if (scl_rise) begin
              rx_q <= {rx_q[6:0], sda_f};
              // Idle keeps a sliding window of the last eight bits
              cnt_q <= (cnt_q == 4'h8) ? 4'h8 : cnt_q + 4'h1;
            end else if (scl_fall && addr_match) begin
              SDA_OE_O <= 1'b1;
              rw_q <= rx_q[0];
              ptr_next_q <= !rx_q[0];
              state_q <= ST_ACK;
              cnt_q <= 4'h0;
            end else if (scl_fall && cnt_q == 4'h8
                         && state_q == ST_ADDR) begin
              state_q <= ST_IDLE;
              cnt_q <= 4'h0;
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              cnt_q <= 4'h0;
              if (rw_q) begin
                tx_q <= rd_data;
                SDA_OE_O <= !rd_data[7];
                ptr_q <= ptr_q + 8'h01;
                state_q <= ST_TX;
              end else begin
                SDA_OE_O <= 1'b0;
                state_q <= ST_RX;
              end
            end
          end
          ST_RX: begin
            if (scl_rise) begin
              rx_q <= {rx_q[6:0], sda_f};
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall && cnt_q == 4'h8) begin
              SDA_OE_O <= 1'b1;
              state_q <= ST_ACK;
              if (ptr_next_q) begin
                ptr_q <= rx_q;
                ptr_next_q <= 1'b0;
              end else begin
                wr_en_q <= 1'b1;
                wr_addr_q <= ptr_q;
                wr_data_q <= rx_q;
                ptr_q <= ptr_q + 8'h01;
              end
            end
          end
          ST_TX: begin
            if (scl_rise) begin
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall && cnt_q == 4'h8) begin
              SDA_OE_O <= 1'b0;
              state_q <= ST_TXACK;
            end else if (scl_fall) begin
              tx_q <= {tx_q[6:0], 1'b0};
              SDA_OE_O <= !tx_q[6];
            end
          end
          ST_TXACK: begin
            if (scl_rise) begin
              mack_q <= !sda_f;
            end else if (scl_fall) begin
              cnt_q <= 4'h0;
              if (mack_q) begin
                tx_q <= rd_data;
                SDA_OE_O <= !rd_data[7];
                ptr_q <= ptr_q + 8'h01;
                state_q <= ST_TX;
              end else begin
                SDA_OE_O <= 1'b0;
                state_q <= ST_IDLE;
              end
            end
          end
          default: begin
            state_q <= ST_IDLE;
            SDA_OE_O <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RSTN_I);

  a_scl_never_driven: assert property (
    !SCL_OE_O)
    else $error("device drives SCL");

  a_sda_pull_low: assert property (
    SDA_OE_O |-> !SDA_O)
    else $error("SDA driven high");

  a_default_addr: assert property (
    !addr_mode |-> slave_addr == 7'h38)
    else $error("default slave address wrong");

  a_strap_addr: assert property (
    addr_mode |-> slave_addr == {4'h7, addr_sel, 1'b0})
    else $error("strap address wrong");

  a_start_busy: assert property (
    start_ev |=> state_q == ST_ADDR && !SDA_OE_O)
    else $error("start not taken");

  a_stop_free: assert property (
    stop_ev |=> state_q == ST_IDLE && !SDA_OE_O)
    else $error("stop not taken");

  a_ack_on_match: assert property (
    (scl_fall && !start_ev && !stop_ev && addr_match
     && (state_q == ST_ADDR || state_q == ST_IDLE))
    |=> SDA_OE_O && state_q == ST_ACK)
    else $error("matching address not acknowledged");

  a_oe_high_stable: assert property (
    (scl_f && scl_p_q && !start_ev && !stop_ev) |=> $stable(SDA_OE_O))
    else $error("SDA changed while SCL high");

  a_ptr_advance: assert property (
    (state_q == ST_RX && scl_fall && cnt_q == 4'h8 && !ptr_next_q
     && !start_ev && !stop_ev)
    |=> wr_en_q && ptr_q == $past(ptr_q) + 8'h01
        ##1 !wr_en_q)
    else $error("write byte not stored or pointer stuck");

  a_not_acknowledge_release: assert property (
    (state_q == ST_TXACK && scl_fall && !mack_q && !start_ev && !stop_ev)
    |=> !SDA_OE_O && state_q == ST_IDLE)
    else $error("data driven after not-acknowledge");

endmodule : twi_slave

// ---- twi_pkg.sv ----
package twi_pkg;

  // ----------------------------------------------------------------
  // Addressing
  // ----------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR_BASE = 7'h38;
  localparam logic [7:0] GLOBAL_ADDR = 8'h80;
  localparam logic [7:0] PTR_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Output gain registers
  // ----------------------------------------------------------------
  localparam logic [7:0] CH0_BANK_A_GAIN_ADDR = 8'h09;
  localparam logic [7:0] CH0_BANK_B_GAIN_ADDR = 8'h29;
  localparam logic [7:0] CH1_BANK_A_GAIN_ADDR = 8'h49;
  localparam logic [7:0] CH1_BANK_B_GAIN_ADDR = 8'h69;
  localparam logic [4:0] GAIN_LOW_ADDR = 5'h09;
  localparam int GAIN_CH_POS = 6;
  localparam int GAIN_BANK_POS = 5;
  localparam logic [7:0] GAIN_A_RESET = 8'h30;
  localparam logic [7:0] GAIN_B_RESET = 8'h3f;
  localparam int GAIN_MSB = 5;
  localparam int GAIN_COUNT = 4;

  // ----------------------------------------------------------------
  // Global register
  // ----------------------------------------------------------------
  localparam int GLB_ADDR_SET_POS = 6;
  localparam logic [5:0] GLB_CTRL_RESET = 6'h3f;

  // ----------------------------------------------------------------
  // Pin filter
  // ----------------------------------------------------------------
  localparam int FILTER_LEN = 3;

  // ----------------------------------------------------------------
  // Serial engine states
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_ACK = 6'h04,
    ST_RX = 6'h08,
    ST_TX = 6'h10,
    ST_TXACK = 6'h20
  } state_t;

endpackage : twi_pkg

// ---- pin_filter.sv ----
`timescale 1ns/1ns
module pin_filter
  import twi_pkg::*;
#(
  parameter int LEN = FILTER_LEN
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic pin_i,
  output logic level_o
);

  // ----------------------------------------------------------------
  // Two-stage synchroniser, then a run-length filter
  // ----------------------------------------------------------------
  logic meta_q;
  logic sync_q;
  logic [3:0] run_q;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else begin
      meta_q <= pin_i;
      sync_q <= meta_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      run_q <= 4'h0;
      level_o <= 1'b1;
    end else if (sync_q == level_o) begin
      run_q <= 4'h0;
    end else if (run_q == 4'(LEN - 1)) begin
      run_q <= 4'h0;
      level_o <= sync_q;
    end else begin
      run_q <= run_q + 4'h1;
    end
  end

endmodule : pin_filter

// ---- config_regs.sv ----
`timescale 1ns/1ns
module config_regs
  import twi_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic wr_en_i,
  input wire logic [7:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic [7:0] rd_addr_i,
  output logic [7:0] rd_data_o,
  input wire logic [1:0] strap_i,
  output logic addr_mode_o,
  output logic [1:0] addr_sel_o,
  output logic [3:0][5:0] gain_o
);

  // ----------------------------------------------------------------
  // Gain register decode
  // ----------------------------------------------------------------
  function automatic logic gain_hit(input logic [7:0] a);
    gain_hit = !a[7] && (a[4:0] == GAIN_LOW_ADDR);
  endfunction : gain_hit

  function automatic logic [1:0] gain_idx(input logic [7:0] a);
    gain_idx = {a[GAIN_CH_POS], a[GAIN_BANK_POS]};
  endfunction : gain_idx

  logic [7:0] gain_q [GAIN_COUNT];
  logic [5:0] ctrl_q;

  // ----------------------------------------------------------------
  // Gain registers, bank A resets low, bank B high
  // ----------------------------------------------------------------
  for (genvar i = 0; i < GAIN_COUNT; i++) begin : g_gain
    always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
        gain_q[i] <= (i % 2 == 1) ? GAIN_B_RESET : GAIN_A_RESET;
      end else if (wr_en_i && gain_hit(wr_addr_i)
                   && gain_idx(wr_addr_i) == 2'(i)) begin
        gain_q[i] <= wr_data_i;
      end
    end
    assign gain_o[i] = gain_q[i][GAIN_MSB:0];
  end

  // ----------------------------------------------------------------
  // Global register, address select latch
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl_q <= GLB_CTRL_RESET;
      addr_mode_o <= 1'b0;
      addr_sel_o <= 2'h0;
    end else if (wr_en_i && wr_addr_i == GLOBAL_ADDR) begin
      ctrl_q <= wr_data_i[5:0];
      addr_mode_o <= wr_data_i[GLB_ADDR_SET_POS];
      if (wr_data_i[GLB_ADDR_SET_POS]) begin
        addr_sel_o <= strap_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read mux, unmapped reads as zero
  // ----------------------------------------------------------------
  always_comb begin
    rd_data_o = 8'h00;
    if (rd_addr_i == GLOBAL_ADDR) begin
      rd_data_o = {addr_sel_o, ctrl_q};
    end else if (gain_hit(rd_addr_i)) begin
      rd_data_o = gain_q[gain_idx(rd_addr_i)];
    end
  end

endmodule : config_regs

// ---- twi_master_model.sv ----
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Bus master model, open-drain, bit-banged on the system clock
// ----------------------------------------------------------------
module twi_master_model #(
  parameter int Q = 10
) (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_low_o,
  output logic sda_low_o
);
  initial begin
    scl_low_o = 1'b0;
    sda_low_o = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick

  task automatic start_cond();
    tick(Q);
    sda_low_o = 1'b1;
    tick(Q);
    scl_low_o = 1'b1;
    tick(Q);
  endtask : start_cond

  task automatic stop_cond();
    sda_low_o = 1'b1;
    tick(Q);
    scl_low_o = 1'b0;
    tick(Q);
    sda_low_o = 1'b0;
    tick(2 * Q);
  endtask : stop_cond

  // Pulls SCL low with SDA high, so no start is seen
  task automatic clock_low();
    scl_low_o = 1'b1;
    tick(Q);
  endtask : clock_low

  // One SCL pulse, SDA sampled mid-high
  task automatic clock_bit(output logic v);
    tick(Q);
    scl_low_o = 1'b0;
    tick(Q);
    v = sda_i;
    tick(Q);
    scl_low_o = 1'b1;
    tick(Q);
  endtask : clock_bit

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic v;
    for (int i = 7; i >= 0; i--) begin
      sda_low_o = ~b[i];
      clock_bit(v);
    end
    sda_low_o = 1'b0;
    clock_bit(v);
    ack = ~v;
  endtask : send_byte

  task automatic recv_byte(input logic ack, output logic [7:0] b);
    logic v;
    sda_low_o = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(v);
      b[i] = v;
    end
    sda_low_o = ack;
    clock_bit(v);
    sda_low_o = 1'b0;
  endtask : recv_byte
endmodule : twi_master_model

// ---- tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
  import twi_pkg::*;
  // Device answer takes ~7 clocks, so SCL runs slower than 28 ns
  localparam int Q = 10;
  logic clk;
  logic rst_n;
  logic strap0;
  logic strap1;
  logic scl_o, scl_oe, sda_o, sda_oe, m_scl_low, m_sda_low;
  logic scl_w, sda_w, prev_scl, prev_oe, a;
  logic [5:0] g0, g1;
  logic [6:0] cur;
  logic [7:0] q [$];
  logic [7:0] ga [4] = '{8'h09, 8'h29, 8'h49, 8'h69};
  logic [7:0] gr [4] = '{8'h30, 8'h3f, 8'h30, 8'h3f};
  int n_fail = 0;
  int n_tests = 0;

  always #2 clk = ~clk;
  // Open-drain wires with pull-ups
  assign scl_w = ~(m_scl_low | scl_oe);
  assign sda_w = ~(m_sda_low | sda_oe);

  twi_slave i_dut (.CLK_I(clk), .RSTN_I(rst_n), .SCL_I(scl_w),
    .SCL_O(scl_o), .SCL_OE_O(scl_oe), .SDA_I(sda_w), .SDA_O(sda_o),
    .SDA_OE_O(sda_oe), .BANK_STRAP_PIN_ZERO_I(strap0),
    .BANK_STRAP_PIN_ONE_I(strap1), .CH0_GAIN_O(g0), .CH1_GAIN_O(g1));
  twi_master_model #(.Q(Q)) i_master (.clk_i(clk), .sda_i(sda_w),
    .scl_low_o(m_scl_low), .sda_low_o(m_sda_low));

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  task automatic fail(input string m);
    n_fail++;
    $display("CHECK FAILED at %0t: %s", $time, m);
  endtask : fail

  task automatic chk_bit(input logic got, input logic exp, input string m);
    n_tests++;
    if (got !== exp) fail(m);
  endtask : chk_bit

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) fail($sformatf("read %h expected %h", got, exp));
  endtask : chk_byte

  task automatic chk_gain(input logic [5:0] got, input logic [5:0] exp);
    n_tests++;
    if (got !== exp) fail($sformatf("gain %h expected %h", got, exp));
  endtask : chk_gain

  always @(posedge clk) begin
    if (rst_n) begin
      if (scl_oe !== 1'b0 || scl_o !== 1'b0) fail("SCL driven");
      if (sda_oe && sda_o !== 1'b0) fail("SDA driven high");
      if (prev_scl && scl_w && sda_oe !== prev_oe) fail("SDA moved");
    end
    prev_scl <= scl_w;
    prev_oe <= sda_oe;
  end

  // ----------------------------------------------------------------
  // Bus transactions
  // ----------------------------------------------------------------
  task automatic probe(input logic [6:0] dev, input logic exp);
    i_master.start_cond();
    i_master.send_byte({dev, 1'b0}, a);
    chk_bit(a, exp, "address answer");
    i_master.stop_cond();
  endtask : probe

  task automatic wr_regs(input logic [6:0] dev, input logic [7:0] ptr,
                         input logic [7:0] d [$]);
    i_master.start_cond();
    i_master.send_byte({dev, 1'b0}, a);
    chk_bit(a, 1'b1, "address not acknowledged");
    i_master.send_byte(ptr, a);
    chk_bit(a, 1'b1, "pointer not acknowledged");
    foreach (d[i]) begin
      i_master.send_byte(d[i], a);
      chk_bit(a, 1'b1, "data not acknowledged");
    end
    i_master.stop_cond();
  endtask : wr_regs

  task automatic rd_chk(input logic [6:0] dev, input logic [7:0] exp [$]);
    logic [7:0] b;
    i_master.start_cond();
    i_master.send_byte({dev, 1'b1}, a);
    chk_bit(a, 1'b1, "read address not acknowledged");
    foreach (exp[i]) begin
      i_master.recv_byte(i != exp.size() - 1, b);
      chk_byte(b, exp[i]);
    end
    chk_bit(sda_oe, 1'b0, "SDA held after not-acknowledge");
    i_master.stop_cond();
  endtask : rd_chk

  task automatic rd_at(input logic [6:0] dev, input logic [7:0] ptr,
                       input logic [7:0] exp);
    q = {};
    wr_regs(dev, ptr, q);
    q.push_back(exp);
    rd_chk(dev, q);
  endtask : rd_at

  task automatic results();
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results

  initial begin
    #300000;
    fail("watchdog expired");
    results();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    strap0 = 1'b0;
    strap1 = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    rst_n = 1'b1;
    i_master.tick(10);
    q = {};
    repeat (9) q.push_back(8'h00);
    q.push_back(8'h30);
    rd_chk(7'h38, q);
    chk_gain(g0, 6'h30);
    chk_gain(g1, 6'h30);
    for (int i = 0; i < 4; i++) begin
      rd_at(7'h38, ga[i], gr[i]);
    end
    $display("test reset_values done");

    q = {8'h11, 8'h2a};
    wr_regs(7'h38, 8'h28, q);
    q = {};
    wr_regs(7'h38, 8'h28, q);
    q = {8'h00, 8'h2a};
    rd_chk(7'h38, q);
    rd_at(7'h38, 8'h28, 8'h00);
    q = {8'hc5};
    wr_regs(7'h38, 8'h09, q);
    rd_at(7'h38, 8'h09, 8'hc5);
    chk_gain(g0, 6'h05);
    q = {8'h15};
    wr_regs(7'h38, 8'h69, q);
    strap0 = 1'b1;
    strap1 = 1'b1;
    i_master.tick(10);
    chk_gain(g0, 6'h2a);
    chk_gain(g1, 6'h15);
    probe(7'h3e, 1'b0);
    probe(7'h38, 1'b1);
    $display("test write_burst done");

    cur = 7'h38;
    for (int s = 0; s < 4; s++) begin
      {strap1, strap0} = 2'(s);
      i_master.tick(10);
      q = {8'h7f};
      wr_regs(cur, 8'h80, q);
      cur = 7'h38 + 7'(2 * s);
      probe(cur, 1'b1);
      probe(cur ^ 7'h02, 1'b0);
      rd_at(cur, 8'h80, {2'(s), 6'h3f});
    end
    {strap1, strap0} = 2'b00;
    i_master.tick(10);
    probe(cur, 1'b1);
    q = {8'h3f};
    wr_regs(cur, 8'h80, q);
    probe(7'h38, 1'b1);
    $display("test address_select done");

    i_master.clock_low();
    i_master.send_byte({7'h38, 1'b0}, a);
    chk_bit(a, 1'b1, "match without start");
    i_master.stop_cond();
    $display("test no_start_match done");
    results();
  end
endmodule : tb_top
